/* File: verilog/pga_spi_pkg.sv */
// Package of constants and types shared by the gain amplifier serial link ends.
package pga_spi_pkg;
   // ****************************************************************
   // Word layout
   // ****************************************************************
   localparam int WORD_BITS = 16;
   localparam int CMD_MSB = 7;
   localparam int CMD_LSB = 5;
   localparam int ADDR_BIT = 0;
   localparam int INPUT_SELECT_BIT = 0;
   localparam int GAIN_CODE_BITS = 3;

   // ****************************************************************
   // Command field codes
   // ****************************************************************
   localparam logic [2:0] CMD_NOP = 3'h0;
   localparam logic [2:0] CMD_SHUTDOWN = 3'h1;
   localparam logic [2:0] CMD_WRITE = 3'h2;
   localparam logic [2:0] CMD_RESERVED = 3'h3;

   // ****************************************************************
   // Compensation settings and timing
   // ****************************************************************
   typedef enum logic [1:0] {
      COMP_LARGE = 2'b00,
      COMP_MEDIUM = 2'b01,
      COMP_SMALL = 2'b10
   } comp_t;

   localparam int CLK_SYS_NS = 100;
   localparam int LINK_PERIOD_NS = 800;
   localparam int LINK_HALF_CYCLES = (LINK_PERIOD_NS / 2 + CLK_SYS_NS - 1) / CLK_SYS_NS;
   localparam int CS_GAP_CYCLES = 4;
endpackage

/* File: verilog/pga_spi_if.sv */
// Interface joining the serial command host and the amplifier command slave.
`timescale 1ns/1ns
interface pga_spi_if;
   logic sck;
   logic cs_n;
   logic sdi;
   logic sdo;

   modport host (output sck, output cs_n, output sdi, input sdo);
   modport device (input sck, input cs_n, input sdi, output sdo);
endinterface

/* File: verilog/pin_sync.sv */
// Two-stage synchroniser for pins arriving from outside the system clock domain.
`timescale 1ns/1ns
module pin_sync #(
   parameter int WIDTH = 3,
   parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
   input wire logic clk_sys_i,
   input wire logic reset_i,
   input wire logic ce_i,
   input wire logic [WIDTH-1:0] pin_i,
   output logic [WIDTH-1:0] sync_o
);
   logic [WIDTH-1:0] meta_ff;
   logic [WIDTH-1:0] sync_ff;

   // Both stages shift together; only the second stage is visible.
   // Reset loads the idle level of each pin, so no false edge follows reset.
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         meta_ff <= RESET_VALUE;
         sync_ff <= RESET_VALUE;
      end else if (ce_i) begin
         meta_ff <= pin_i;
         sync_ff <= meta_ff;
      end
   end

   assign sync_o = sync_ff;
endmodule

/* File: verilog/pga_spi_slave.sv */
// Amplifier command slave: serial receiver, command decode and control state.
//
// Design decisions made here: strobed register access and the register offsets.
`timescale 1ns/1ns
// Functional notes
// - Chip select low frames; ignore link otherwise.
// - First byte instruction, second byte data.
// - Support clock idle low and high modes.
// - Sample rising edge, shift out falling.
// - Mode 0,0: select fall presents first bit.
// - Non-multiple-of-16 clock count aborts execution.
// - Output low when deselected, always driven.
// - Execute only on chip select rise.
// - Registers undefined until host writes them.
// - One select cycle restores known state.
// - Command bits 7-5, address bit 0.
// - 000 no-op, 010 write, 011 unused.
// - Address one channel, zero gain.
// - Shutdown disables amplifier, output high impedance.
// - Leave shutdown on valid write only.
// - Registers kept through shutdown.
// - Channel bit 0 selects input.
// - Gains one to thirty-two, compensation tracks.
// - Select rise clears shift register.
module pga_spi_slave #(
   parameter bit TWO_INPUTS = 1'b1
) (
   input wire logic clk_sys_i,
   input wire logic reset_i,
   input wire logic ce_i,
   pga_spi_if.device link,
   output logic [7:0] gain_reg_o,
   output logic [7:0] input_select_reg_o,
   output logic [5:0] gain_vv_o,
   output pga_spi_pkg::comp_t comp_o,
   output logic input_one_sel_o,
   output logic amp_enable_o,
   output logic amp_out_oe_n_o,
   output logic exec_pulse_o,
   output logic abort_pulse_o
);
   // ****************************************************************
   // Helpers
   // ****************************************************************
   // Gain code to volts per volt.
   function automatic logic [5:0] gain_of(input logic [2:0] code);
      logic [5:0] g;
      g = 6'h01;
      unique case (code)
         3'h0: g = 6'h01;
         3'h1: g = 6'h02;
         3'h2: g = 6'h04;
         3'h3: g = 6'h05;
         3'h4: g = 6'h08;
         3'h5: g = 6'h0A;
         3'h6: g = 6'h10;
         3'h7: g = 6'h20;
      endcase
      return g;
   endfunction

   // Gain code to compensation capacitor choice.
   function automatic pga_spi_pkg::comp_t comp_of(input logic [2:0] code);
      pga_spi_pkg::comp_t c;
      c = pga_spi_pkg::COMP_LARGE;
      if (code >= 3'h6) begin
         c = pga_spi_pkg::COMP_SMALL;
      end else if (code >= 3'h2) begin
         c = pga_spi_pkg::COMP_MEDIUM;
      end
      return c;
   endfunction

   // ****************************************************************
   // Pin synchronisation and edge detection
   // ****************************************************************
   logic [2:0] pins_s;
   logic sck_s, cs_n_s, sdi_s;
   logic sck_d_ff, cs_n_d_ff;
   logic sck_rise, sck_fall, cs_fall, cs_rise;

   // Order is clock, select, data; select idles high, so it resets high.
   pin_sync #(.WIDTH(3), .RESET_VALUE(3'h2)) u_sync (
      .clk_sys_i(clk_sys_i),
      .reset_i(reset_i),
      .ce_i(ce_i),
      .pin_i({link.sck, link.cs_n, link.sdi}),
      .sync_o(pins_s)
   );

   assign sck_s = pins_s[2];
   assign cs_n_s = pins_s[1];
   assign sdi_s = pins_s[0];

   // Previous values for edge detection; reset as deselected.
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         sck_d_ff <= 1'b0;
         cs_n_d_ff <= 1'b1;
      end else if (ce_i) begin
         sck_d_ff <= sck_s;
         cs_n_d_ff <= cs_n_s;
      end
   end

   // Clock edges count only inside a frame, so idle level does not matter.
   assign sck_rise = !cs_n_s && sck_s && !sck_d_ff;
   assign sck_fall = !cs_n_s && !sck_s && sck_d_ff;
   assign cs_fall = cs_n_d_ff && !cs_n_s;
   assign cs_rise = !cs_n_d_ff && cs_n_s;

   // ****************************************************************
   // Shift path
   // ****************************************************************
   logic [15:0] shift_ff;
   logic [3:0] bit_cnt_ff;
   logic word_seen_ff;
   logic sdo_ff;
   logic [15:0] last_word_ff;

   // Receive shifter, clocked in MSB first on rising edges.
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         shift_ff <= '0;
         bit_cnt_ff <= '0;
         word_seen_ff <= 1'b0;
      end else if (ce_i) begin
         if (cs_rise || cs_fall) begin
            shift_ff <= '0;
            bit_cnt_ff <= '0;
            word_seen_ff <= 1'b0;
         end else if (sck_rise) begin
            shift_ff <= {shift_ff[14:0], sdi_s};
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
            if (bit_cnt_ff == 4'hF) begin
               word_seen_ff <= 1'b1;
            end
         end
      end
   end

   // Latest complete word; the instruction byte is its upper half.
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         last_word_ff <= '0;
      end else if (ce_i && sck_rise && bit_cnt_ff == 4'hF) begin
         last_word_ff <= {shift_ff[14:0], sdi_s};
      end
   end

   // Serial output shifts on falling edges; first bit shows at select fall.
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         sdo_ff <= 1'b0;
      end else if (ce_i) begin
         if (cs_n_s) begin
            sdo_ff <= 1'b0;
         end else if (cs_fall) begin
            sdo_ff <= 1'b0; // cleared shifter gives its MSB, zero
         end else if (sck_fall && bit_cnt_ff != 4'h0) begin
            sdo_ff <= shift_ff[15];
         end else if (sck_fall) begin
            sdo_ff <= shift_ff[15];
         end
      end
   end

   assign link.sdo = sdo_ff;

   // ****************************************************************
   // Command execution
   // ****************************************************************
   logic [7:0] gain_ff, chan_ff;
   logic shut_ff, exec_ff, abort_ff;
   logic [2:0] cmd;
   logic addr_bit, frame_ok;

   assign cmd = last_word_ff[8 + pga_spi_pkg::CMD_MSB : 8 + pga_spi_pkg::CMD_LSB];
   assign addr_bit = last_word_ff[8 + pga_spi_pkg::ADDR_BIT];
   assign frame_ok = word_seen_ff && (bit_cnt_ff == 4'h0);

   // Registers change only on an executed write; no reset value is promised.
   always_ff @(posedge clk_sys_i) begin
      if (ce_i && cs_rise && frame_ok && cmd == pga_spi_pkg::CMD_WRITE) begin
         if (addr_bit) begin
            chan_ff <= last_word_ff[7:0];
         end else begin
            gain_ff <= last_word_ff[7:0];
         end
      end
   end

   // Shutdown state: entered by code 001, left by a write, others ignored.
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         shut_ff <= 1'b0;
      end else if (ce_i && cs_rise && frame_ok) begin
         if (cmd == pga_spi_pkg::CMD_SHUTDOWN) begin
            shut_ff <= 1'b1;
         end else if (cmd == pga_spi_pkg::CMD_WRITE) begin
            shut_ff <= 1'b0;
         end
      end
   end

   // Execution and abort pulses, registered one cycle after the select rise.
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         exec_ff <= 1'b0;
         abort_ff <= 1'b0;
      end else if (ce_i) begin
         exec_ff <= cs_rise && frame_ok;
         abort_ff <= cs_rise && !frame_ok;
      end
   end

   // ****************************************************************
   // Analog control outputs
   // ****************************************************************
   assign gain_reg_o = {5'h00, gain_ff[pga_spi_pkg::GAIN_CODE_BITS-1:0]};
   assign input_select_reg_o = {7'h00, chan_ff[pga_spi_pkg::INPUT_SELECT_BIT]};
   assign gain_vv_o = gain_of(gain_ff[2:0]);
   assign comp_o = comp_of(gain_ff[2:0]);
   assign input_one_sel_o = TWO_INPUTS & chan_ff[pga_spi_pkg::INPUT_SELECT_BIT];
   assign amp_enable_o = !shut_ff;
   assign amp_out_oe_n_o = shut_ff;
   assign exec_pulse_o = exec_ff;
   assign abort_pulse_o = abort_ff;
endmodule

/* File: verilog/pga_spi_host.sv */
// Serial command host: frames words from a register port onto the link.
`timescale 1ns/1ns
module pga_spi_host #(
   parameter int MAX_WORDS = 4
) (
   input wire logic clk_sys_i,
   input wire logic reset_i,
   input wire logic ce_i,
   pga_spi_if.host link,
   input wire logic [1:0] addr_i,
   input wire logic [15:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [15:0] rdata_o
);
   // Register map: 0 tx word, 1 control (bit0 go, bit1 mode1,1, bits 6:4 words-1),
   // 2 status (bit0 busy), 3 last received word.
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_LOW = 2'b01,
      ST_HIGH = 2'b10,
      ST_GAP = 2'b11
   } hstate_t;

   hstate_t state_ff;
   logic [15:0] tx_ff, rx_ff, shift_ff, rdata_ff;
   logic [2:0] words_ff, word_cnt_ff;
   logic mode11_ff, sck_ff, cs_n_ff, sdi_ff;
   logic [3:0] bit_ff;
   logic [3:0] tick_ff;
   logic sdo_s;
   logic tick;

   pin_sync #(.WIDTH(1)) u_sync (
      .clk_sys_i(clk_sys_i),
      .reset_i(reset_i),
      .ce_i(ce_i),
      .pin_i(link.sdo),
      .sync_o(sdo_s)
   );

   assign tick = (tick_ff == 4'(pga_spi_pkg::LINK_HALF_CYCLES - 1));

   // Half-period divider for the serial clock.
   always_ff @(posedge clk_sys_i) begin
      if (reset_i || state_ff == ST_IDLE) begin
         tick_ff <= '0;
      end else if (ce_i) begin
         tick_ff <= tick ? 4'h0 : tick_ff + 4'h1;
      end
   end

   // Register writes from software.
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         tx_ff <= '0;
         words_ff <= '0;
         mode11_ff <= 1'b0;
      end else if (ce_i && wr_i) begin
         if (addr_i == 2'h0) begin
            tx_ff <= wdata_i;
         end else if (addr_i == 2'h1 && state_ff == ST_IDLE) begin
            mode11_ff <= wdata_i[1];
            words_ff <= wdata_i[6:4];
         end
      end
   end

   // Framing state machine: whole 16-bit words, then select rise.
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         state_ff <= ST_IDLE;
         cs_n_ff <= 1'b1;
         sck_ff <= 1'b0;
         sdi_ff <= 1'b0;
         bit_ff <= '0;
         word_cnt_ff <= '0;
         shift_ff <= '0;
         rx_ff <= '0;
      end else if (ce_i) begin
         unique case (state_ff)
            ST_IDLE: begin
               sck_ff <= mode11_ff;
               if (wr_i && addr_i == 2'h1 && wdata_i[0]) begin
                  // Clock idling high needs a falling lead-in before the first rise.
                  state_ff <= mode11_ff ? ST_GAP : ST_LOW;
                  cs_n_ff <= 1'b0;
                  sdi_ff <= tx_ff[15];
                  shift_ff <= {tx_ff[14:0], 1'b0};
                  bit_ff <= '0;
                  word_cnt_ff <= '0;
               end
            end
            ST_LOW: if (tick) begin
               sck_ff <= 1'b1;
               state_ff <= ST_HIGH;
               rx_ff <= {rx_ff[14:0], sdo_s};
            end
            ST_HIGH: if (tick) begin
               bit_ff <= bit_ff + 4'h1;
               if (bit_ff == 4'hF && word_cnt_ff == words_ff) begin
                  cs_n_ff <= 1'b1;
                  sck_ff <= mode11_ff;
                  state_ff <= ST_GAP;
               end else begin
                  sck_ff <= 1'b0;
                  sdi_ff <= shift_ff[15];
                  shift_ff <= (bit_ff == 4'hF) ? tx_ff : {shift_ff[14:0], 1'b0};
                  if (bit_ff == 4'hF) begin
                     word_cnt_ff <= word_cnt_ff + 3'h1;
                     sdi_ff <= tx_ff[15];
                     shift_ff <= {tx_ff[14:0], 1'b0};
                  end
                  state_ff <= ST_LOW;
               end
            end
            ST_GAP: if (tick) begin
               if (cs_n_ff) begin
                  state_ff <= ST_IDLE;
               end else begin
                  sck_ff <= 1'b0; // lead-in fall while selected
                  state_ff <= ST_LOW;
               end
            end
         endcase
      end
   end

   // Read data one cycle after the strobe.
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         rdata_ff <= '0;
      end else if (ce_i && rd_i) begin
         unique case (addr_i)
            2'h0: rdata_ff <= tx_ff;
            2'h1: rdata_ff <= {9'h000, words_ff, 2'b00, mode11_ff, 1'b0};
            2'h2: rdata_ff <= {15'h0000, state_ff != ST_IDLE};
            2'h3: rdata_ff <= rx_ff;
         endcase
      end
   end

   assign rdata_o = rdata_ff;
   assign link.sck = sck_ff;
   assign link.cs_n = cs_n_ff;
   assign link.sdi = sdi_ff;
endmodule

/* File: sim/pga_spi_checker.sv */
// Checker of the serial link between the command host and the slave.
`timescale 1ns/1ns
module pga_spi_checker (
   input wire logic clk_sys_i,
   input wire logic reset_i,
   input wire logic sck,
   input wire logic cs_n,
   input wire logic sdi,
   input wire logic sdo
);
   logic sck_ff;
   logic [7:0] cnt_ff;
   logic [15:0] word_ff;

   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (reset_i);

   // ********
   // Frame bookkeeping
   // ********
   // Counts clock rises in a frame and keeps the first word sent.
   always_ff @(posedge clk_sys_i) begin
      sck_ff <= sck;
      if (cs_n) begin
         cnt_ff <= 8'h00;
      end else if (sck && !sck_ff) begin
         cnt_ff <= cnt_ff + 8'h01;
         if (cnt_ff < 8'h10) begin
            word_ff <= {word_ff[14:0], sdi};
         end
      end
   end

   // ********
   // Link properties
   // ********
   a_sdo_idle_low: assert property (cs_n [*6] |-> !sdo)
      else $error("sdo not low while deselected");
   a_first_word_zero: assert property (!cs_n && cnt_ff < 8'h10 |-> !sdo)
      else $error("first word out is not zero");
   a_chain_delay: assert property ($rose(sck) && !cs_n && cnt_ff[7:4] == 4'h1
      |-> sdo == word_ff[~cnt_ff[3:0]])
      else $error("sdo is not the word shifted in before");
   a_sdo_on_fall: assert property ($changed(sdo) |-> !sck || cs_n)
      else $error("sdo moved while clock high");
   a_whole_words: assert property ($rose(cs_n) |-> cnt_ff != 8'h00 && cnt_ff[3:0] == 4'h0)
      else $error("frame is not whole words");
   a_sck_half: assert property (!cs_n && $changed(sck) |=> $stable(sck) [*3])
      else $error("clock half period too short");
   a_sdi_at_rise: assert property (!cs_n && $rose(sck) |-> $stable(sdi))
      else $error("sdi moved at clock rise");
   a_exec_gap: assert property ($rose(cs_n) |=> cs_n [*3])
      else $error("select high too short");

   c_one_word: cover property ($rose(cs_n) && cnt_ff == 8'h10);
   c_four_words: cover property ($rose(cs_n) && cnt_ff == 8'h40);
   c_mode_high: cover property ($fell(cs_n) && sck);
endmodule

/* File: sim/test_pga_spi_gain_channel_control.sv */
// Self-checking bench for both ends of the gain amplifier serial link.
`timescale 1ns/1ns
module test_pga_spi_gain_channel_control;
   logic clk_sys_i = 1'b0;
   logic reset_i = 1'b1;
   logic [1:0] addr = 2'h0;
   logic [15:0] wdata = 16'h0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [15:0] rdata;
   logic [7:0] gain_reg, sel_reg;
   logic [5:0] vv, vv2;
   pga_spi_pkg::comp_t comp;
   logic one_sel, amp_en, oe_n, exec, abort, exec2, abort2;
   int n_errors = 0;
   int tests_run = 0;
   int n_exec = 0;
   int n_abort = 0;
   int n_exec2 = 0;
   int n_abort2 = 0;
   logic [5:0] vv_tab [8] = '{6'h01, 6'h02, 6'h04, 6'h05, 6'h08, 6'h0a, 6'h10, 6'h20};

   pga_spi_if link ();
   pga_spi_if bad_link ();

   // Clock of 100 ns.
   always #50 clk_sys_i = ~clk_sys_i;

   pga_spi_host pga_spi_host_i (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .ce_i(1'b1),
      .link(link.host), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata));
   pga_spi_slave pga_spi_slave_i (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .ce_i(1'b1),
      .link(link.device), .gain_reg_o(gain_reg), .input_select_reg_o(sel_reg), .gain_vv_o(vv),
      .comp_o(comp), .input_one_sel_o(one_sel), .amp_enable_o(amp_en), .amp_out_oe_n_o(oe_n),
      .exec_pulse_o(exec), .abort_pulse_o(abort));
   pga_spi_slave pga_spi_slave_b_i (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .ce_i(1'b1),
      .link(bad_link.device), .gain_reg_o(), .input_select_reg_o(), .gain_vv_o(vv2),
      .comp_o(), .input_one_sel_o(), .amp_enable_o(), .amp_out_oe_n_o(),
      .exec_pulse_o(exec2), .abort_pulse_o(abort2));
   pga_spi_checker pga_spi_checker_i (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
      .sck(link.sck), .cs_n(link.cs_n), .sdi(link.sdi), .sdo(link.sdo));

   // Counts executed and aborted frames of both slaves.
   always @(posedge clk_sys_i) begin
      if (!reset_i && exec === 1'b1) n_exec <= n_exec + 1;
      if (!reset_i && abort === 1'b1) n_abort <= n_abort + 1;
      if (!reset_i && exec2 === 1'b1) n_exec2 <= n_exec2 + 1;
      if (!reset_i && abort2 === 1'b1) n_abort2 <= n_abort2 + 1;
   end

   // ********
   // Shared tasks
   // ********
   task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      tests_run++;
      if (got !== exp) begin
         $display("BAD %s expected %h seen %h", what, exp, got);
         n_errors++;
      end
   endtask

   task reg_wr(input logic [1:0] a, input logic [15:0] d);
      @(posedge clk_sys_i);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk_sys_i);
      wr <= 1'b0;
   endtask

   task reg_rd(input logic [1:0] a, output logic [15:0] d);
      @(posedge clk_sys_i);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_sys_i);
      rd <= 1'b0;
      #1 d = rdata;
   endtask

   // Sends a frame of nwm1 + 1 copies of one word through the host.
   task send(input logic [15:0] w, input logic [2:0] nwm1, input logic mode);
      int k;
      logic [15:0] st;
      reg_wr(2'h0, w);
      reg_wr(2'h1, {9'h000, nwm1, 2'b00, mode, 1'b0});
      reg_wr(2'h1, {9'h000, nwm1, 2'b00, mode, 1'b1});
      repeat (4) @(posedge clk_sys_i);
      st = 16'h0001;
      for (k = 0; k < 300 && st[0] !== 1'b0; k++) reg_rd(2'h2, st);
      chk("busy", 16'h0000, {15'h0000, st[0]});
      repeat (12) @(posedge clk_sys_i);
   endtask

   // Drives the second link by hand in clock-idle-low mode with n clocks.
   task bang(input int n, input logic [15:0] w);
      int i;
      @(posedge clk_sys_i);
      bad_link.cs_n <= 1'b0;
      bad_link.sdi <= w[15];
      for (i = 1; i <= n; i++) begin
         repeat (4) @(posedge clk_sys_i);
         bad_link.sck <= 1'b1;
         repeat (4) @(posedge clk_sys_i);
         bad_link.sck <= 1'b0;
         bad_link.sdi <= w[15 - i % 16];
      end
      repeat (4) @(posedge clk_sys_i);
      bad_link.cs_n <= 1'b1;
      bad_link.sdi <= ~bad_link.sdi;
      repeat (12) @(posedge clk_sys_i);
   endtask

   // ********
   // Scenarios
   // ********
   task t_gain;
      int c;
      for (c = 0; c < 8; c++) begin
         send({pga_spi_pkg::CMD_WRITE, 5'h00, 8'(c)}, 3'h0, c[0]);
         chk("gain", 16'(vv_tab[c]), 16'(vv));
         chk("code", 16'(c), 16'(gain_reg[2:0]));
         chk("comp", 16'(c < 2 ? pga_spi_pkg::COMP_LARGE : c < 6 ? pga_spi_pkg::COMP_MEDIUM
            : pga_spi_pkg::COMP_SMALL), 16'(comp));
      end
      chk("exec", 16'h0008, 16'(n_exec));
      $display("gain test done");
   endtask

   task t_channel;
      logic [15:0] st;
      send({pga_spi_pkg::CMD_WRITE, 5'h01, 8'h01}, 3'h1, 1'b0);
      chk("input one", 16'h0001, 16'(one_sel));
      chk("select reg", 16'h0001, 16'(sel_reg[0]));
      chk("gain kept", 16'h0020, 16'(vv));
      send({pga_spi_pkg::CMD_WRITE, 5'h01, 8'hfe}, 3'h3, 1'b1);
      chk("input zero", 16'h0000, 16'(one_sel));
      reg_rd(2'h1, st);
      chk("control", 16'h0032, st);
      chk("exec", 16'h000a, 16'(n_exec));
      $display("channel test done");
   endtask

   task t_shutdown;
      int c;
      send({pga_spi_pkg::CMD_WRITE, 5'h00, 8'h03}, 3'h0, 1'b0);
      send({pga_spi_pkg::CMD_SHUTDOWN, 13'h0000}, 3'h0, 1'b0);
      chk("amp off", 16'h0000, 16'(amp_en));
      chk("out high z", 16'h0001, 16'(oe_n));
      for (c = 0; c < 8; c++) begin
         if (c != 2) send({3'(c), 5'h00, 8'h07}, 3'h0, 1'b1);
      end
      chk("still off", 16'h0000, 16'(amp_en));
      chk("nop gain", 16'h0005, 16'(vv));
      send({pga_spi_pkg::CMD_WRITE, 5'h01, 8'h00}, 3'h0, 1'b0);
      chk("amp on", 16'h0001, 16'(amp_en));
      chk("out on", 16'h0000, 16'(oe_n));
      chk("gain resumed", 16'h0005, 16'(vv));
      $display("shutdown test done");
   endtask

   task t_abort;
      bang(16, {pga_spi_pkg::CMD_WRITE, 5'h00, 8'h00});
      chk("first exec", 16'h0001, 16'(n_exec2));
      chk("first gain", 16'h0001, 16'(vv2));
      bang(24, {pga_spi_pkg::CMD_WRITE, 5'h00, 8'h07});
      chk("part word", 16'h0001, 16'(n_abort2));
      chk("gain held", 16'h0001, 16'(vv2));
      bang(0, 16'h0000);
      chk("no clocks", 16'h0002, 16'(n_abort2));
      bang(32, {pga_spi_pkg::CMD_WRITE, 5'h00, 8'h06});
      chk("two words", 16'h0010, 16'(vv2));
      chk("good aborts", 16'h0000, 16'(n_abort));
      $display("abort test done");
   endtask

   // Prints the counts and the verdict, then stops.
   task finish_test;
      $display("checks %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // Main sequence.
   initial begin
      bad_link.cs_n = 1'b1;
      bad_link.sck = 1'b0;
      bad_link.sdi = 1'b0;
      repeat (16) @(posedge clk_sys_i);
      reset_i <= 1'b0;
      t_gain;
      t_channel;
      t_shutdown;
      t_abort;
      finish_test;
   end

   // Cuts a hang short.
   initial begin
      #5_000_000;
      n_errors++;
      $display("BAD watchdog expected end seen hang");
      finish_test;
   end
endmodule
